// [verilog/vipb_page_builder.sv]
// Top of the VPD inquiry page builder: byte streamer for pages 88h, B1h, D2h
`timescale 1ns/100ps
`default_nettype none
module vipb_page_builder
	import vipb_pkg::*;
#(
	parameter logic [27:0] WWN_PREFIX = 28'h0a1b2c3 // Maker prefix, arbitrary value
) (
	input wire logic clk, // System clock, 10 MHz
	input wire logic rst_n, // Synchronous reset, active low
	input wire logic reqValid, // Request strobe
	input wire logic [7:0] reqPageCode, // Requested page code
	input wire logic [15:0] allocLen, // Allocation length in bytes
	input wire logic mediaAvail, // Media available
	input wire logic protoIsSas, // High for SAS, low for Fibre Channel
	input wire logic [vipb_pkg::WWN_BLOCK_W-1:0] wwnBlock, // Per-model block assignment
	input wire logic [vipb_pkg::WWN_SERIAL_W-1:0] wwnSerial, // Drive unique serial
	input wire logic strWrEn, // String byte write strobe
	input wire logic [6:0] strWrAddr, // String byte address
	input wire logic [7:0] strWrData, // String byte value
	input wire logic byteReady, // Transport takes a byte
	output logic busy, // Page in progress
	output logic byteValid, // Byte on byteData is valid
	output logic [7:0] byteData, // Page byte
	output logic byteLast, // Final byte of the transfer
	output logic pageDone, // Transfer finished pulse
	output logic pageUnsupported // Unknown page code pulse
);
	import vipb_pkg::*;

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	vipb_str_if strIf ();
	vipb_state_t state;
	logic [7:0] pageCode;
	logic mediaHeld;
	logic sasHeld;
	logic [63:0] uniquePortNamePri;
	logic [63:0] uniquePortNameSec;
	logic [6:0] idx;
	logic [15:0] limit;
	logic [7:0] curByte;
	logic [2:0] curField;
	logic [6:0] curPos;
	logic moreBytes;
	logic slotFree;

	// ---------------------------------------------------------------
	// Helper functions
	// ---------------------------------------------------------------

	// Whole page size including the four header bytes
	function automatic logic [7:0] pageTotal(input logic [7:0] code);
		case (code)
			PG_PORT_ID: return LEN_PORT_ID + HDR_BYTES;
			PG_BLOCK_CHAR: return LEN_BLOCK_CHAR + HDR_BYTES;
			PG_CARD_ID: return LEN_CARD_ID + HDR_BYTES;
			default: return 8'h00;
		endcase
	endfunction

	// Builds one port name
	function automatic logic [63:0] makeName(input logic [1:0] sel,
		input logic [WWN_BLOCK_W-1:0] blk, input logic [WWN_SERIAL_W-1:0] ser);
		return {WWN_PREFIX, blk, sel, ser};
	endfunction

	// Picks byte k of a name, most significant first
	function automatic logic [7:0] nameByte(input logic [63:0] w, input logic [2:0] k);
		logic [63:0] sh;
		sh = w << {k, 3'b000};
		return sh[63:56];
	endfunction

	// Splits a card page index into field number and offset in field
	function automatic logic [9:0] splitCard(input logic [6:0] i);
		logic [6:0] p;
		logic [2:0] f;
		p = i - 7'(HDR_BYTES);
		f = 3'h0;
		for (int n = 0; n < STR_FIELDS - 1; n++) begin
			if (p >= FIELD_SPAN) begin
				p = p - FIELD_SPAN;
				f = f + 3'h1;
			end
		end
		return {f, p};
	endfunction

	// Protocol nibble and code set of a descriptor
	function automatic logic [7:0] protoByte(input logic sas);
		return {(sas ? PROTO_SAS : PROTO_FC), CODE_SET_BIN};
	endfunction

	// Valid flag, association and identifier type of a descriptor
	function automatic logic [7:0] assocByte();
		return {PROTO_ID_VALID, 1'b0, ASSOC_PORT, ID_TYPE_NAA};
	endfunction

	// Port identification page content
	function automatic logic [7:0] portPageByte(input logic [6:0] i, input logic sas,
		input logic [63:0] w0, input logic [63:0] w1);
		logic [7:0] b;
		b = 8'h00;
		if (i >= WWN_PRI_POS && i < WWN_PRI_POS + 7'd8) begin
			b = nameByte(w0, 3'(i - WWN_PRI_POS));
		end else if (i >= WWN_SEC_POS && i < WWN_SEC_POS + 7'd8) begin
			b = nameByte(w1, 3'(i - WWN_SEC_POS));
		end else begin
			case (i)
				7'd3: b = LEN_PORT_ID;
				7'd7: b = REL_PORT_PRI;
				7'd15: b = DESC_LEN;
				7'd16: b = protoByte(sas);
				7'd17: b = assocByte();
				7'd19: b = ID_LEN;
				7'd31: b = REL_PORT_SEC;
				7'd39: b = DESC_LEN;
				7'd40: b = protoByte(sas);
				7'd41: b = assocByte();
				7'd43: b = ID_LEN;
				default: b = 8'h00;
			endcase
		end
		return b;
	endfunction

	// Block characteristics page content
	function automatic logic [7:0] blockPageByte(input logic [6:0] i);
		case (i)
			7'd3: return LEN_BLOCK_CHAR;
			7'd5: return ROT_RATE_SSD;
			7'd7: return {4'h0, FORM_FACTOR};
			default: return 8'h00;
		endcase
	endfunction

	// Card identification page content past the header
	function automatic logic [7:0] cardPageByte(input logic [6:0] pos, input logic media,
		input logic [7:0] s);
		logic [7:0] b;
		b = ASCII_SPACE;
		if (pos == FIELD_TERM) begin
			b = ASCII_NULL;
		end else if (!media) begin
			b = ASCII_SPACE;
		end else if (pos == 7'd0) begin
			b = STR_LEN;
		end else begin
			b = s;
		end
		return b;
	endfunction

	// Byte i of the selected page
	function automatic logic [7:0] pageByte(input logic [7:0] code, input logic [6:0] i,
		input logic [7:0] cardByte, input logic [7:0] portByte);
		logic [7:0] b;
		b = 8'h00;
		if (i == 7'd0) begin
			b = {QUALIFIER, DEV_TYPE};
		end else if (i == 7'd1) begin
			b = code;
		end else if (code == PG_CARD_ID) begin
			b = (i == 7'd3) ? LEN_CARD_ID : (i == 7'd2) ? 8'h00 : cardByte;
		end else if (code == PG_BLOCK_CHAR) begin
			b = blockPageByte(i);
		end else begin
			b = portByte;
		end
		return b;
	endfunction

	// ---------------------------------------------------------------
	// String store
	// ---------------------------------------------------------------

	// Write path straight from the ports, read path from the index
	assign strIf.wrEn = strWrEn;
	assign strIf.wrAddr = strWrAddr;
	assign strIf.wrData = strWrData;
	assign strIf.rdAddr = idx - 7'(HDR_BYTES) - 7'd1 - {4'h0, curField};

	vipb_string_store #(
		.DEPTH(STR_BYTES)
	) vipb_string_store_inst (
		.clk(clk),
		.rst_n(rst_n),
		.port(strIf.store)
	);

	// ---------------------------------------------------------------
	// Byte selection
	// ---------------------------------------------------------------

	// Card page field split and content of the current index
	assign {curField, curPos} = splitCard(idx);
	assign curByte = pageByte(pageCode, idx,
		cardPageByte(curPos, mediaHeld, strIf.rdData),
		portPageByte(idx, sasHeld, uniquePortNamePri, uniquePortNameSec));

	// Output slot can take a byte, and one remains below the limit
	assign slotFree = !byteValid || byteReady;
	assign moreBytes = {9'h000, idx} < limit;

	// ---------------------------------------------------------------
	// Request capture
	// ---------------------------------------------------------------

	// Page code, media state, protocol and names held for the transfer
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pageCode <= 8'h00;
			mediaHeld <= 1'b0;
			sasHeld <= 1'b0;
			uniquePortNamePri <= 64'h0;
			uniquePortNameSec <= 64'h0;
			limit <= 16'h0000;
		end else if (state == ST_IDLE && reqValid) begin
			pageCode <= reqPageCode;
			mediaHeld <= mediaAvail;
			sasHeld <= protoIsSas;
			uniquePortNamePri <= makeName(SEL_PORT_PRI, wwnBlock, wwnSerial);
			uniquePortNameSec <= makeName(SEL_PORT_SEC, wwnBlock, wwnSerial);
			// Shorter of page size and allocation length
			limit <= (allocLen < {8'h00, pageTotal(reqPageCode)}) ? allocLen :
				{8'h00, pageTotal(reqPageCode)};
		end
	end

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------

	// Idle until a known page is asked for, then stream until the limit
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			busy <= 1'b0;
		end else begin
			case (state)
				ST_IDLE: begin
					if (reqValid && pageTotal(reqPageCode) != 8'h00) begin
						state <= ST_SEND;
						busy <= 1'b1;
					end
				end
				ST_SEND: begin
					if (slotFree && !moreBytes) begin
						state <= ST_IDLE;
						busy <= 1'b0;
					end
				end
				default: begin
					state <= ST_IDLE;
					busy <= 1'b0;
				end
			endcase
		end
	end

	// Byte index walks upward one byte per accepted slot
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			idx <= 7'd0;
		end else if (state == ST_IDLE) begin
			idx <= 7'd0;
		end else if (slotFree && moreBytes) begin
			idx <= idx + 7'd1;
		end
	end

	// ---------------------------------------------------------------
	// Output stream
	// ---------------------------------------------------------------

	// Registered byte slot with ready back-pressure
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			byteValid <= 1'b0;
			byteData <= 8'h00;
			byteLast <= 1'b0;
		end else if (state == ST_SEND && slotFree) begin
			byteValid <= moreBytes;
			byteData <= moreBytes ? curByte : 8'h00;
			byteLast <= moreBytes && ({9'h000, idx} == limit - 16'h0001);
		end else if (state != ST_SEND) begin
			byteValid <= 1'b0;
			byteLast <= 1'b0;
		end
	end

	// Completion and unknown page pulses
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pageDone <= 1'b0;
			pageUnsupported <= 1'b0;
		end else begin
			pageDone <= (state == ST_SEND) && slotFree && !moreBytes;
			pageUnsupported <= (state == ST_IDLE) && reqValid &&
				(pageTotal(reqPageCode) == 8'h00);
		end
	end

endmodule // vipb_page_builder
`default_nettype wire

// [verilog/vipb_pkg.sv]
// Constants and types shared by the VPD inquiry page builder files
package vipb_pkg;

	// ---------------------------------------------------------------
	// Page codes
	// ---------------------------------------------------------------
	localparam logic [7:0] PG_PORT_ID = 8'h88;
	localparam logic [7:0] PG_BLOCK_CHAR = 8'hb1;
	localparam logic [7:0] PG_CARD_ID = 8'hd2;

	// ---------------------------------------------------------------
	// Common header byte 0 and page lengths
	// ---------------------------------------------------------------
	localparam logic [2:0] QUALIFIER = 3'h0;
	localparam logic [4:0] DEV_TYPE = 5'h00;
	localparam logic [7:0] LEN_PORT_ID = 8'h30;
	localparam logic [7:0] LEN_BLOCK_CHAR = 8'h3c;
	localparam logic [7:0] LEN_CARD_ID = 8'h78;
	localparam logic [7:0] HDR_BYTES = 8'h04;

	// ---------------------------------------------------------------
	// Port descriptor fields
	// ---------------------------------------------------------------
	localparam logic [3:0] PROTO_FC = 4'h0;
	localparam logic [3:0] PROTO_SAS = 4'h6;
	localparam logic [3:0] CODE_SET_BIN = 4'h1;
	localparam logic PROTO_ID_VALID = 1'b1;
	localparam logic [1:0] ASSOC_PORT = 2'h1;
	localparam logic [3:0] ID_TYPE_NAA = 4'h3;
	localparam logic [7:0] DESC_LEN = 8'h0c;
	localparam logic [7:0] ID_LEN = 8'h08;
	localparam logic [7:0] REL_PORT_PRI = 8'h01;
	localparam logic [7:0] REL_PORT_SEC = 8'h02;
	localparam logic [6:0] WWN_PRI_POS = 7'd20;
	localparam logic [6:0] WWN_SEC_POS = 7'd44;
	localparam logic [1:0] SEL_PORT_PRI = 2'h1;
	localparam logic [1:0] SEL_PORT_SEC = 2'h2;
	localparam int WWN_BLOCK_W = 12;
	localparam int WWN_SERIAL_W = 22;

	// ---------------------------------------------------------------
	// Block characteristics and card identification fields
	// ---------------------------------------------------------------
	localparam logic [7:0] ROT_RATE_SSD = 8'h01;
	localparam logic [3:0] FORM_FACTOR = 4'h3;
	localparam logic [7:0] STR_LEN = 8'h13;
	localparam logic [7:0] ASCII_SPACE = 8'h20;
	localparam logic [7:0] ASCII_NULL = 8'h00;
	localparam logic [6:0] FIELD_SPAN = 7'd20;
	localparam logic [6:0] FIELD_TERM = 7'd19;
	localparam int STR_FIELDS = 6;
	localparam int STR_CHARS = 19;
	localparam int STR_BYTES = STR_FIELDS * STR_CHARS;

	// ---------------------------------------------------------------
	// Sequencer states
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_SEND = 2'b10
	} vipb_state_t;

endpackage

// [verilog/vipb_str_if.sv]
// Interface between the page sequencer and the card string store
`timescale 1ns/100ps
`default_nettype none
interface vipb_str_if;
	logic wrEn;
	logic [6:0] wrAddr;
	logic [7:0] wrData;
	logic [6:0] rdAddr;
	logic [7:0] rdData;
	modport user (output wrEn, output wrAddr, output wrData, output rdAddr, input rdData);
	modport store (input wrEn, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface
`default_nettype wire

// [verilog/vipb_string_store.sv]
// Storage for the six card identification strings
`timescale 1ns/100ps
`default_nettype none
module vipb_string_store
	import vipb_pkg::*;
#(
	parameter int DEPTH = STR_BYTES
) (
	input wire logic clk, // System clock
	input wire logic rst_n, // Synchronous reset, active low
	vipb_str_if.store port // Write and read port
);
	import vipb_pkg::*;

	logic [7:0] mem [DEPTH];

	// True for digits and letters of either case
	function automatic logic isAlnum(input logic [7:0] c);
		return (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h5a) ||
			(c >= 8'h61 && c <= 8'h7a);
	endfunction

	// Writes store only alphanumerics, anything else becomes a blank
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int n = 0; n < DEPTH; n++) begin
				mem[n] <= ASCII_SPACE;
			end
		end else if (port.wrEn && 32'(port.wrAddr) < DEPTH) begin
			mem[port.wrAddr] <= isAlnum(port.wrData) ? port.wrData : ASCII_SPACE;
		end
	end

	// Asynchronous read, blanks outside the array
	assign port.rdData = (32'(port.rdAddr) < DEPTH) ? mem[port.rdAddr] : ASCII_SPACE;

endmodule // vipb_string_store
`default_nettype wire

// [verif/vipb_page_builder_sva.sv]
// Port assertions for the page builder
`timescale 1ns/100ps
`default_nettype none
module vipb_page_builder_sva
	import vipb_pkg::*;
(
	input wire logic clk, // Clock
	input wire logic rst_n, // Reset
	input wire logic reqValid, // Request
	input wire logic [7:0] reqPageCode, // Code
	input wire logic byteReady, // Taken
	input wire logic busy, // Busy
	input wire logic byteValid, // Offered
	input wire logic [7:0] byteData, // Byte
	input wire logic byteLast, // Last
	input wire logic pageDone, // Done
	input wire logic pageUnsupported // Refused
);
	logic [7:0] capCode;
	logic [7:0] idx;
	logic known;
	// ---------------------------------------------------------------
	// Helper state
	// ---------------------------------------------------------------
	// Known page codes
	assign known = reqPageCode inside {PG_PORT_ID, PG_BLOCK_CHAR, PG_CARD_ID};
	// Requested code
	always_ff @(posedge clk) begin
		if (!rst_n) capCode <= 8'h00;
		else if (reqValid && !busy) capCode <= reqPageCode;
	end
	// Index of the offered byte
	always_ff @(posedge clk) begin
		if (!rst_n || (reqValid && !busy)) idx <= 8'h00;
		else if (byteValid && byteReady) idx <= idx + 8'h01;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	a_known_starts: assert property (reqValid && !busy && known |=> busy && !pageUnsupported)
		else $error("known code not started");
	a_unknown_refused: assert property (reqValid && !busy && !known |=> pageUnsupported && !busy ##1 !pageUnsupported)
		else $error("unknown code not refused");
	a_byte_held: assert property (byteValid && !byteReady |=> byteValid && $stable(byteData) && $stable(byteLast))
		else $error("byte not held");
	a_last_ends: assert property (byteValid && byteReady && byteLast |=> !byteValid && pageDone && !busy)
		else $error("transfer did not end");
	a_first_header: assert property ($rose(byteValid) |-> byteData == {QUALIFIER, DEV_TYPE} && idx == 8'h00)
		else $error("bad first byte");
	a_code_echo: assert property (byteValid && idx == 8'h01 |-> byteData == capCode)
		else $error("code not echoed");
	a_length_byte: assert property (byteValid && idx == 8'h03 |-> byteData == ((capCode == PG_PORT_ID) ? 8'h30 :
		(capCode == PG_BLOCK_CHAR) ? 8'h3c : 8'h78))
		else $error("bad page length");
	a_valid_busy: assert property (byteValid |-> busy)
		else $error("byte outside a page");
	a_done_pulse: assert property (pageDone |=> !pageDone && !byteValid)
		else $error("done not a pulse");
	a_last_marked: assert property (pageDone && $past(byteValid) |-> $past(byteLast) && $past(byteReady))
		else $error("final byte not marked");
endmodule // vipb_page_builder_sva
bind vipb_page_builder vipb_page_builder_sva vipb_page_builder_sva_inst (.clk(clk), .rst_n(rst_n),
	.reqValid(reqValid), .reqPageCode(reqPageCode), .byteReady(byteReady), .busy(busy), .byteValid(byteValid),
	.byteData(byteData), .byteLast(byteLast), .pageDone(pageDone), .pageUnsupported(pageUnsupported));
`default_nettype wire

// [verif/vipb_host_sink.sv]
// Transport-side sink that takes page bytes
`timescale 1ns/100ps
`default_nettype none
module vipb_host_sink (
	input wire logic clk, // Clock
	input wire logic rst_n, // Reset
	input wire logic stall, // Slow acceptance
	input wire logic clear, // Empty the buffer
	input wire logic byteValid, // Offered
	input wire logic [7:0] byteData, // Byte
	output logic byteReady, // Taken
	output logic [7:0] rxCount // Bytes held
);
	logic [7:0] rxBuf [0:127];
	// Ready, toggling while stalled
	always @(negedge clk) begin
		if (!rst_n) byteReady <= 1'b0;
		else byteReady <= stall ? ~byteReady : 1'b1;
	end
	// Keep accepted bytes in order
	always @(posedge clk) begin
		if (!rst_n || clear) rxCount <= 8'h00;
		else if (byteValid && byteReady) begin
			rxBuf[rxCount] <= byteData;
			rxCount <= rxCount + 8'h01;
		end
	end
endmodule // vipb_host_sink
`default_nettype wire

// [verif/vipb_page_builder_bench.sv]
// Self-checking bench for the page builder
`timescale 1ns/100ps
`default_nettype none
module vipb_page_builder_bench;
	localparam logic [27:0] PREFIX = 28'h3c5d7e9; // Arbitrary maker prefix
	logic clk, rst_n, reqValid, mediaAvail, protoIsSas, strWrEn, byteReady, stall, clear;
	logic busy, byteValid, byteLast, pageDone, pageUnsupported;
	logic [7:0] reqPageCode, strWrData, byteData, rxCount;
	logic [7:0] strMem [0:113];
	logic [15:0] allocLen;
	logic [11:0] wwnBlock;
	logic [21:0] wwnSerial;
	logic [6:0] strWrAddr;
	int errors, checked, cycles;
	vipb_page_builder #(.WWN_PREFIX(PREFIX)) vipb_page_builder_inst (.clk(clk), .rst_n(rst_n), .reqValid(reqValid),
		.reqPageCode(reqPageCode), .allocLen(allocLen), .mediaAvail(mediaAvail), .protoIsSas(protoIsSas),
		.wwnBlock(wwnBlock), .wwnSerial(wwnSerial), .strWrEn(strWrEn), .strWrAddr(strWrAddr), .strWrData(strWrData),
		.byteReady(byteReady), .busy(busy), .byteValid(byteValid), .byteData(byteData), .byteLast(byteLast),
		.pageDone(pageDone), .pageUnsupported(pageUnsupported));
	vipb_host_sink vipb_host_sink_inst (.clk(clk), .rst_n(rst_n), .stall(stall), .clear(clear),
		.byteValid(byteValid), .byteData(byteData), .byteReady(byteReady), .rxCount(rxCount));
	// ---------------------------------------------------------------
	// Checking helpers
	// ---------------------------------------------------------------
	task automatic final_report;
		$display("Comparisons %0d, mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		checked++;
		if (seen !== want) begin
			errors++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, want);
		end
	endtask
	// Expected page byte
	function automatic logic [7:0] expB(input logic [7:0] code, input int i);
		logic [63:0] w;
		int p;
		p = (i - 4) % 20;
		w = {PREFIX, wwnBlock, (i < 40) ? 2'b01 : 2'b10, wwnSerial};
		if (i == 1) return code;
		if (code == 8'h88) begin
			if (i >= 20 && i <= 27) return w[8*(27-i) +: 8];
			if (i >= 44) return w[8*(51-i) +: 8];
			case (i)
				3: return 8'h30;
				7: return 8'h01;
				31: return 8'h02;
				15, 39: return 8'h0c;
				16, 40: return {protoIsSas ? 4'h6 : 4'h0, 4'h1};
				17, 41: return 8'h93;
				19, 43: return 8'h08;
				default: return 8'h00;
			endcase
		end
		if (code == 8'hb1) return (i == 3) ? 8'h3c : (i == 5) ? 8'h01 : (i == 7) ? 8'h03 : 8'h00;
		if (i == 3) return 8'h78;
		if (i < 4 || p == 19) return 8'h00;
		if (!mediaAvail) return 8'h20;
		if (p == 0) return 8'h13;
		return strMem[(i - 4) / 20 * 19 + p - 1];
	endfunction
	// One request, a refused poke while busy, count check
	task automatic req(input logic [7:0] code, input logic [15:0] alloc, input logic known);
		int k;
		logic uns;
		logic [15:0] sz;
		sz = (code == 8'h88) ? 16'd52 : (code == 8'hb1) ? 16'd64 : (code == 8'hd2) ? 16'd124 : 16'd0;
		@(negedge clk);
		clear = 1'b1;
		@(negedge clk);
		clear = 1'b0;
		reqValid = 1'b1;
		reqPageCode = code;
		allocLen = alloc;
		@(negedge clk);
		uns = pageUnsupported;
		reqValid = 1'b0;
		for (k = 0; k < 600; k++) begin
			if (pageDone || (!known && k == 3)) break;
			reqValid = (k == 5 && alloc > 16'd8);
			if (k == 5) reqPageCode = 8'hb1;
			@(negedge clk);
		end
		reqValid = 1'b0;
		check(uns, known ? 1'b0 : 1'b1);
		check(pageDone, known);
		check(rxCount, (alloc < sz) ? alloc : sz);
	endtask
	// Compare every captured byte
	task automatic cmp_page(input logic [7:0] code);
		int k;
		for (k = 0; k < rxCount; k++) check(vipb_host_sink_inst.rxBuf[k], expB(code, k));
	endtask
	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_port;
		stall = 1'b1;
		req(8'h88, 16'd100, 1'b1);
		cmp_page(8'h88);
		protoIsSas = 1'b1;
		stall = 1'b0;
		req(8'h88, 16'd52, 1'b1);
		cmp_page(8'h88);
	endtask
	task automatic t_block;
		req(8'hb1, 16'd300, 1'b1);
		cmp_page(8'hb1);
	endtask
	task automatic t_card;
		int a;
		for (a = 0; a < 114; a += 4) begin
			@(negedge clk);
			strWrEn = 1'b1;
			strWrAddr = a[6:0];
			strWrData = (a == 8) ? 8'h2d : 8'h41 + 8'(a % 26);
			strMem[a] = (a == 8) ? 8'h20 : 8'h41 + 8'(a % 26);
		end
		@(negedge clk);
		strWrEn = 1'b0;
		stall = 1'b1;
		req(8'hd2, 16'd124, 1'b1);
		cmp_page(8'hd2);
		mediaAvail = 1'b0;
		req(8'hd2, 16'd200, 1'b1);
		cmp_page(8'hd2);
	endtask
	task automatic t_trunc;
		req(8'hb1, 16'd2, 1'b1);
		cmp_page(8'hb1);
		req(8'h88, 16'd0, 1'b1);
		req(8'h12, 16'd16, 1'b0);
	endtask
	// ---------------------------------------------------------------
	// Clock, timeout and main sequence
	// ---------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			final_report;
		end
	end
	initial begin
		{rst_n, reqValid, protoIsSas, strWrEn, stall, clear} = 6'h00;
		mediaAvail = 1'b1;
		reqPageCode = 8'h00;
		allocLen = 16'h0000;
		wwnBlock = 12'ha5c;
		wwnSerial = 22'h1a2b3c;
		strWrAddr = 7'h00;
		strWrData = 8'h00;
		foreach (strMem[i]) strMem[i] = 8'h20;
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		t_port;
		t_block;
		t_card;
		t_trunc;
		final_report;
	end
endmodule // vipb_page_builder_bench
`default_nettype wire
